// ===== core/mahp_defs.svh
// timing constants, widths and strap encodings for the multiplexed host port
`ifndef MAHP_DEFS_SVH
`define MAHP_DEFS_SVH
`define MAHP_CLK_PERIOD_NS 10
`define MAHP_ADDR_W 16
`define MAHP_DATA_W 32
`define MAHP_BUS_W 16
`define MAHP_BYTE_W 8
`define MAHP_LANES_16 2'h2
`define MAHP_LANES_8 2'h3
`define MAHP_ALL_BYTES 4'hF
`define MAHP_NO_BYTES 4'h0
`define MAHP_ONE_BYTE 4'h1
`define MAHP_TWO_BYTES 4'h3
`define MAHP_LANES_NONE 16'h0000
`define MAHP_LANES_BYTE 16'h00FF
`define MAHP_LANES_WORD 16'hFFFF
`endif

// ===== core/mahp_pkg.sv
// types shared by the multiplexed host port files
package mahp_pkg;
	typedef enum logic [2:0] {
		MAHP_IDLE = 3'b001,
		MAHP_READ = 3'b010,
		MAHP_WRITE = 3'b100
	} mahp_state_type;
endpackage

// ===== core/mahp_strobe_decode.sv
// strap-controlled polarity and style decode of the host control pins
`timescale 1ns/1ns
`default_nettype none
module mahp_strobe_decode (
	input wire logic lowAddrLatchStrobe,
	input wire logic highAddrLatchStrobe,
	input wire logic chipSelect,
	input wire logic readLine,
	input wire logic writeLine,
	input wire logic strobeStyleSelectStrap,
	input wire logic latchStrobePolarityStrap,
	input wire logic selectPolarityStrap,
	input wire logic readLinePolarityStrap,
	input wire logic writeLinePolarityStrap,
	output logic lowLatch,
	output logic highLatch,
	output logic readActive,
	output logic writeActive
);
	logic selActive;
	logic rdLvl;
	logic wrLvl;
	// a strap value of one means the line is active high
	always_comb begin
		selActive = chipSelect ~^ selectPolarityStrap;
		rdLvl = readLine ~^ readLinePolarityStrap;
		wrLvl = writeLine ~^ writeLinePolarityStrap;
		lowLatch = lowAddrLatchStrobe ~^ latchStrobePolarityStrap;
		highLatch = highAddrLatchStrobe ~^ latchStrobePolarityStrap;
		if (strobeStyleSelectStrap) begin
			// direction line plus transfer enable strobe; readLine carries direction
			readActive = selActive && wrLvl && rdLvl;
			writeActive = selActive && wrLvl && !rdLvl;
		end else begin
			readActive = selActive && rdLvl && !wrLvl;
			writeActive = selActive && wrLvl && !rdLvl;
		end
	end
endmodule
`default_nettype wire

// ===== core/mahp_host_port.sv
// multiplexed address/data host port: latching, lane steering, dword assembly
`timescale 1ns/1ns
`default_nettype none
`include "mahp_defs.svh"
// Summary of operation
// - dual-phase mode latches low then high address byte from bits 7:0 per strobe.
// - dual-phase 16-bit address phases ignore bus bits 15:8.
// - 16-bit mode moves data on all sixteen lines, driven on reads.
// - 8-bit mode moves data only on bits 7:0, never touching 15:8.
// - single-phase mode captures both address bytes at once from all lines.
// - single-phase 8-bit mode leaves bits 15:8 undriven during data phase.
// - dual-phase mode: skipped high strobe keeps the previously latched high address byte.
// - repeated reads and writes to one latched halfword are allowed.
// - repeated reads and writes to one latched byte are allowed.
// - strobes in any order or skipped; last latched bytes are kept.
// - strobe, select and read/write polarity and style are strap selected.
module mahp_host_port
	import mahp_pkg::*;
#(
	parameter int ADDR_W = `MAHP_ADDR_W,
	parameter int DATA_W = `MAHP_DATA_W
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic lowAddrLatchStrobe,
	input wire logic highAddrLatchStrobe,
	input wire logic chipSelect,
	input wire logic readLine,
	input wire logic writeLine,
	input wire logic [15:0] busIn,
	output logic [15:0] busOut,
	output logic [15:0] busOutEnable,
	input wire logic strobeStyleSelectStrap,
	input wire logic latchStrobePolarityStrap,
	input wire logic selectPolarityStrap,
	input wire logic readLinePolarityStrap,
	input wire logic writeLinePolarityStrap,
	input wire logic singlePhaseMode,
	input wire logic byteWideMode,
	output logic [ADDR_W-1:0] regAddr,
	output logic regWriteStrobe,
	output logic [DATA_W-1:0] regWriteData,
	input wire logic [DATA_W-1:0] regReadData,
	output logic regReadStrobe
);
	logic lowLatch;
	logic highLatch;
	logic readActive;
	logic writeActive;
	mahp_state_type state_reg, state_next;
	logic [7:0] addrLo_reg, addrLo_next;
	logic [7:0] addrHi_reg, addrHi_next;
	logic [DATA_W-1:0] hold_reg, hold_next;
	logic [3:0] written_reg, written_next;
	logic [DATA_W-1:0] snap_reg, snap_next;
	logic [3:0] readSeen_reg, readSeen_next;
	logic [15:0] outData_reg, outData_next;
	logic [15:0] outEn_reg, outEn_next;
	logic commit_reg, commit_next;
	logic rdStrobe_reg, rdStrobe_next;
	logic [3:0] partMask;
	logic [1:0] byteSel;
	logic [DATA_W-1:0] srcWord;
	logic [4:0] shiftAmt;

	mahp_strobe_decode u_decode (
		.lowAddrLatchStrobe(lowAddrLatchStrobe),
		.highAddrLatchStrobe(highAddrLatchStrobe),
		.chipSelect(chipSelect),
		.readLine(readLine),
		.writeLine(writeLine),
		.strobeStyleSelectStrap(strobeStyleSelectStrap),
		.latchStrobePolarityStrap(latchStrobePolarityStrap),
		.selectPolarityStrap(selectPolarityStrap),
		.readLinePolarityStrap(readLinePolarityStrap),
		.writeLinePolarityStrap(writeLinePolarityStrap),
		.lowLatch(lowLatch),
		.highLatch(highLatch),
		.readActive(readActive),
		.writeActive(writeActive)
	);

	// ----------------------------------------------------------------
	// lane selection within the dword
	// ----------------------------------------------------------------
	always_comb begin
		if (byteWideMode) begin
			byteSel = addrLo_reg[1:0];
			partMask = 4'(`MAHP_ONE_BYTE << byteSel);
		end else begin
			byteSel = {addrLo_reg[1], 1'b0};
			partMask = 4'(`MAHP_TWO_BYTES << byteSel);
		end
		shiftAmt = {byteSel, 3'h0};
	end

	// ----------------------------------------------------------------
	// address latching, data transfer and dword assembly
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		addrLo_next = addrLo_reg;
		addrHi_next = addrHi_reg;
		hold_next = hold_reg;
		written_next = written_reg;
		snap_next = snap_reg;
		readSeen_next = readSeen_reg;
		outData_next = outData_reg;
		outEn_next = `MAHP_LANES_NONE;
		commit_next = 1'b0;
		rdStrobe_next = 1'b0;
		srcWord = snap_reg;
		// strobes not given leave the old byte in place
		if (lowLatch) begin
			addrLo_next = busIn[7:0];
			if (singlePhaseMode) begin
				addrHi_next = busIn[15:8];
			end
		end
		if (highLatch && !singlePhaseMode) begin
			addrHi_next = busIn[7:0];
		end
		case (state_reg)
			MAHP_IDLE: begin
				if (readActive) begin
					state_next = MAHP_READ;
					// a part already read, or no part read yet, starts a new dword: take a fresh snapshot
					if ((readSeen_reg & partMask) != `MAHP_NO_BYTES || readSeen_reg == `MAHP_NO_BYTES) begin
						srcWord = regReadData;
						snap_next = regReadData;
						readSeen_next = partMask;
						rdStrobe_next = 1'b1;
					end else begin
						readSeen_next = readSeen_reg | partMask;
					end
					if (readSeen_next == `MAHP_ALL_BYTES) begin
						readSeen_next = `MAHP_NO_BYTES;
					end
					outData_next = 16'(srcWord >> shiftAmt);
					if (byteWideMode) begin
						outEn_next = `MAHP_LANES_BYTE;
					end else begin
						outEn_next = `MAHP_LANES_WORD;
					end
				end else if (writeActive) begin
					state_next = MAHP_WRITE;
				end
			end
			MAHP_READ: begin
				// hold the lanes for the whole read strobe
				outEn_next = outEn_reg;
				if (!readActive) begin
					state_next = MAHP_IDLE;
					outEn_next = `MAHP_LANES_NONE;
				end
			end
			MAHP_WRITE: begin
				// data is sampled at the trailing edge of the write strobe
				if (!writeActive) begin
					state_next = MAHP_IDLE;
					if (byteWideMode) begin
						hold_next[shiftAmt +: `MAHP_BYTE_W] = busIn[7:0];
					end else begin
						hold_next[shiftAmt +: `MAHP_BUS_W] = busIn;
					end
					written_next = written_reg | partMask;
					if (written_next == `MAHP_ALL_BYTES) begin
						commit_next = 1'b1;
						written_next = `MAHP_NO_BYTES;
					end
				end
			end
			default: begin
				state_next = MAHP_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_reg <= MAHP_IDLE;
			addrLo_reg <= 8'h00;
			addrHi_reg <= 8'h00;
			hold_reg <= '0;
			written_reg <= `MAHP_NO_BYTES;
			snap_reg <= '0;
			readSeen_reg <= `MAHP_NO_BYTES;
			outData_reg <= 16'h0000;
			outEn_reg <= `MAHP_LANES_NONE;
			commit_reg <= 1'b0;
			rdStrobe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addrLo_reg <= addrLo_next;
			addrHi_reg <= addrHi_next;
			hold_reg <= hold_next;
			written_reg <= written_next;
			snap_reg <= snap_next;
			readSeen_reg <= readSeen_next;
			outData_reg <= outData_next;
			outEn_reg <= outEn_next;
			commit_reg <= commit_next;
			rdStrobe_reg <= rdStrobe_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign busOut = outData_reg;
	assign busOutEnable = outEn_reg;
	assign regAddr = ADDR_W'({addrHi_reg, addrLo_reg[7:2], 2'b00});
	assign regWriteStrobe = commit_reg;
	assign regWriteData = hold_reg;
	assign regReadStrobe = rdStrobe_reg;
endmodule
`default_nettype wire

// ===== dv/mahp_host_port_chk.sv
// assertions on the multiplexed host port
`timescale 1ns/1ns
`default_nettype none
module mahp_host_port_chk (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic chipSelect,
	input wire logic readLine,
	input wire logic writeLine,
	input wire logic strobeStyleSelectStrap,
	input wire logic selectPolarityStrap,
	input wire logic readLinePolarityStrap,
	input wire logic writeLinePolarityStrap,
	input wire logic byteWideMode,
	input wire logic [15:0] busOutEnable,
	input wire logic regWriteStrobe,
	input wire logic regReadStrobe
);
	// in the combined style readLine gives the direction and writeLine the enable
	wire logic sel = chipSelect == selectPolarityStrap;
	wire logic rdAct = sel && readLine == readLinePolarityStrap &&
		(writeLine == writeLinePolarityStrap) == strobeStyleSelectStrap;
	wire logic wrAct = sel && writeLine == writeLinePolarityStrap && readLine != readLinePolarityStrap;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	sequence s_noRead;
		!rdAct [*2];
	endsequence
	chk_byte_lanes: assert property (byteWideMode && |busOutEnable |-> busOutEnable == 16'h00FF)
		else $error("byte lanes wrong");
	chk_word_lanes: assert property (!byteWideMode && |busOutEnable |-> busOutEnable == 16'hFFFF)
		else $error("word lanes wrong");
	chk_read_drive: assert property ($rose(rdAct) |-> ##[1:2] busOutEnable != 16'h0000)
		else $error("read not driven");
	chk_read_release: assert property ($fell(rdAct) |=> busOutEnable == 16'h0000)
		else $error("bus held");
	chk_idle_quiet: assert property (s_noRead |=> busOutEnable == 16'h0000)
		else $error("idle bus driven");
	chk_snap_pulse: assert property (regReadStrobe |-> $past(rdAct))
		else $error("stray snapshot");
	chk_write_end: assert property (regWriteStrobe |-> !$past(wrAct) && ($past(wrAct, 2) || $past(wrAct, 3)))
		else $error("stray commit");
	chk_write_once: assert property (regWriteStrobe |=> !regWriteStrobe)
		else $error("long commit");
endmodule
bind mahp_host_port mahp_host_port_chk chk_u (.sys_clk, .reset, .chipSelect, .readLine, .writeLine, .strobeStyleSelectStrap,
	.selectPolarityStrap, .readLinePolarityStrap, .writeLinePolarityStrap, .byteWideMode, .busOutEnable,
	.regWriteStrobe, .regReadStrobe);
`default_nettype wire

// ===== dv/mahp_host_model.sv
// host controller model driving strobes and the shared bus
`timescale 1ns/1ns
`default_nettype none
module mahp_host_model (
	input wire logic sys_clk,
	input wire logic pol,
	input wire logic single,
	input wire logic style,
	input wire logic [15:0] busIn,
	output logic [4:0] ctl,
	output logic [15:0] hostBus
);
	// active bits: low latch, high latch, select, read, write
	// with style set, the read bit is the direction and the write bit the enable
	logic [4:0] act = 5'h00;
	assign ctl = act ^ {5{~pol}};
	initial hostBus = 16'hC35A;
	task automatic latch(input logic [7:0] lo, input logic [7:0] hi, input logic useHi);
		@(negedge sys_clk) act[4] = 1'b1;
		hostBus = single ? {hi, lo} : {~lo, lo};
		@(negedge sys_clk) act[4] = 1'b0;
		hostBus = ~hostBus;
		if (useHi && !single) begin
			@(negedge sys_clk) act[3] = 1'b1;
			hostBus = {lo, hi};
			@(negedge sys_clk) act[3] = 1'b0;
			hostBus = ~hostBus;
		end
	endtask
	task automatic rd(output logic [15:0] d);
		@(negedge sys_clk) act[2:0] = {2'b11, style};
		repeat (3) @(negedge sys_clk);
		d = busIn;
		act[2:0] = 3'b000;
		@(negedge sys_clk);
	endtask
	task automatic wr(input logic [15:0] d);
		@(negedge sys_clk) act[2:0] = 3'b101;
		hostBus = d;
		repeat (2) @(negedge sys_clk);
		// data held through the edge that samples it
		act[0] = 1'b0;
		@(negedge sys_clk) act[2] = 1'b0;
		hostBus = ~d;
	endtask
endmodule
`default_nettype wire

// ===== dv/test_muxed_addr_data_host_port.sv
// self-checking bench for the multiplexed host port
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_muxed_addr_data_host_port;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic pol = 1'b1;
	logic style = 1'b0;
	int nSnaps = 0;
	logic singlePhaseMode = 1'b0;
	logic byteWideMode = 1'b0;
	logic [31:0] regReadData = 32'hA1B2C3D4;
	logic [31:0] wData = 32'h0;
	logic [15:0] got;
	int n_mismatch = 0;
	int checks_done = 0;
	int nWrites = 0;
	wire logic lowAddrLatchStrobe, highAddrLatchStrobe, chipSelect, readLine, writeLine, regWriteStrobe, regReadStrobe;
	wire logic [15:0] hostBus, busOut, busOutEnable, busIn, regAddr;
	wire logic [31:0] regWriteData;
	assign busIn = (busOut & busOutEnable) | (hostBus & ~busOutEnable);
	always #5 sys_clk = ~sys_clk;
	mahp_host_model m_u (.sys_clk, .pol, .single(singlePhaseMode), .style, .busIn, .hostBus,
		.ctl({lowAddrLatchStrobe, highAddrLatchStrobe, chipSelect, readLine, writeLine}));
	mahp_host_port dut_u (.sys_clk, .reset, .lowAddrLatchStrobe, .highAddrLatchStrobe, .chipSelect, .readLine,
		.writeLine, .busIn, .busOut, .busOutEnable, .strobeStyleSelectStrap(style), .latchStrobePolarityStrap(pol),
		.selectPolarityStrap(pol), .readLinePolarityStrap(pol), .writeLinePolarityStrap(pol), .singlePhaseMode,
		.byteWideMode, .regAddr, .regWriteStrobe, .regWriteData, .regReadData, .regReadStrobe);
	always @(posedge sys_clk) if (regWriteStrobe === 1'b1) begin
		nWrites++;
		wData = regWriteData;
	end
	always @(posedge sys_clk) if (regReadStrobe === 1'b1) nSnaps++;
	task automatic t_word();
		m_u.latch(8'h10, 8'h12, 1'b1);
		m_u.wr(16'h1111);
		m_u.latch(8'h12, 8'h00, 1'b0);
		m_u.wr(16'h2222);
		repeat (3) @(negedge sys_clk);
		`CHK("addr", 16'h1210, regAddr)
		`CHK("wdata", 32'h22221111, wData)
		`CHK("writes", 1, nWrites)
		m_u.rd(got);
		`CHK("rd hi", 16'hA1B2, got)
		regReadData = 32'h55667788;
		m_u.rd(got);
		`CHK("reread", 16'h5566, got)
		regReadData = 32'h0;
		m_u.latch(8'h10, 8'h00, 1'b0);
		m_u.rd(got);
		`CHK("rd lo", 16'h7788, got)
		`CHK("snaps", 2, nSnaps)
	endtask
	task automatic t_byte_read();
		singlePhaseMode = 1'b1;
		byteWideMode = 1'b1;
		regReadData = 32'hA1B2C3D4;
		for (int i = 0; i < 4; i++) begin
			m_u.latch(8'h40 + 8'(i), 8'h34, 1'b0);
			m_u.rd(got);
			regReadData = 32'h0;
			`CHK("rd byte", 8'(32'hA1B2C3D4 >> (8 * i)), got[7:0])
		end
		`CHK("addr1", 16'h3440, regAddr)
	endtask
	task automatic t_byte_write();
		pol = 1'b0;
		singlePhaseMode = 1'b0;
		nWrites = 0;
		m_u.latch(8'h80, 8'h56, 1'b1);
		m_u.wr(16'hFF77);
		for (int i = 0; i < 4; i++) begin
			m_u.latch(8'h80 + 8'(i), 8'h00, 1'b0);
			m_u.wr({8'hEE, 8'h11 * 8'(i + 1)});
		end
		repeat (3) @(negedge sys_clk);
		`CHK("wdata8", 32'h44332211, wData)
		`CHK("writes8", 1, nWrites)
		`CHK("addr8", 16'h5680, regAddr)
	endtask
	task automatic t_combined();
		style = 1'b1;
		pol = 1'b1;
		singlePhaseMode = 1'b1;
		byteWideMode = 1'b0;
		nWrites = 0;
		regReadData = 32'h13579BDF;
		m_u.latch(8'h20, 8'h78, 1'b0);
		m_u.wr(16'hBEEF);
		m_u.latch(8'h22, 8'h78, 1'b0);
		m_u.wr(16'hCAFE);
		repeat (3) @(negedge sys_clk);
		`CHK("wdata c", 32'hCAFEBEEF, wData)
		`CHK("writes c", 1, nWrites)
		`CHK("addr c", 16'h7820, regAddr)
		m_u.rd(got);
		`CHK("rd c", 16'h1357, got)
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge sys_clk);
		reset = 1'b0;
		t_word();
		t_byte_read();
		t_byte_write();
		t_combined();
		end_of_test();
	end
	// the tests need about 125 cycles
	initial begin
		#20000;
		n_mismatch++;
		end_of_test();
	end
endmodule
`default_nettype wire
